// ===== core/ttm_timer.sv
// Purpose: one 24-bit timer channel, toggle/event/measure/pwm modes
// Assumes: pin may be asynchronous to core_clk (two-stage synchroniser), prescaler tick supplied as pulse
// Notes: interrupt lines are level requests to an outside controller
//
// Notes on behaviour
// - mode field is control bits 7..4
// - enable clears counter, first tick loads
// - flags clear on write-one or service
// - toggle mode pin starts at polarity
// - toggle match inverts pin, sets flag
// - toggle/event match or overflow, pwm overflow, reloads when reload set
// - event clock is pin or prescaler tick
// - external clock synchronised, below clk/4
// - polarity picks falling or rising count edge
// - event match sets compare flag
// - measured counts may be one off
// - width mode start edge loads counter
// - width mode opposite edge captures, stops only with reload
// - width mode reload restarts on start edge
// - period mode same-edge pair captures count
// - period reload repeats, else runs on
// - capture edge sets flag, halts, copies
// - capture polarity picks ending edge
// - pwm match toggles pin, captures count
// - pwm overflow toggles pin, sets overflow
// - pwm pin starts at polarity level
// - period all-ones minus load plus one
// - pwm no-reload overflow readout takes load
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module ttm_timer
  import ttm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire ttm_pkg::ttm_bus_req_t bus_req,
  output logic [ttm_pkg::CW-1:0] rdata,
  // interrupt service acknowledges and prescaler tick
  input wire logic compare_ack,
  input wire logic overflow_ack,
  input wire logic presc_tick,
  // timer pin
  input wire logic timer_io_pin_i,
  output ttm_pkg::ttm_pin_out_t timer_io_pin,
  // interrupt requests
  output logic compare_irq,
  output logic overflow_irq
);
  import ttm_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // control word fields
  logic timer_enable_bit;
  logic compare_irq_enable;
  logic overflow_irq_enable;
  logic polarity_select;
  logic reload_mode;
  logic presc_src;
  logic [3:0] mode_select_field;

  // status flags, set by hardware and cleared by software or service
  logic compare_flag;
  logic overflow_flag;

  // data registers and the running count
  logic [CW-1:0] load_value_reg;
  logic [CW-1:0] compare_value_reg;
  logic [CW-1:0] count_readout_reg;
  logic [CW-1:0] count_reg;

  // pin level and sequencing
  logic pin_reg;
  ttm_state_t state_reg;
  logic first_reg;
  logic reload_pend_reg;

  // pin sampling
  logic [SYNC_STAGES-1:0] sync_reg;
  logic samp_prev_reg;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  wire ctrl_wr = bus_req.wr && bus_req.addr == ADDR_CTRL;
  wire en_rise = ctrl_wr && bus_req.wdata[BIT_EN] && !timer_enable_bit;
  // decisions taken on the enabling write follow the mode being written,
  // not the one it replaces
  wire [3:0] wr_mode = bus_req.wdata[MODE_HI:MODE_LO];
  wire [3:0] mode_next = ctrl_wr ? wr_mode : mode_select_field;
  wire en_next = ctrl_wr ? bus_req.wdata[BIT_EN] : timer_enable_bit;
  wire start_armed = wr_mode == MODE_WIDTH || wr_mode == MODE_PERIOD;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      timer_enable_bit <= 1'b0;
      compare_irq_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
      polarity_select <= 1'b0;
      reload_mode <= 1'b0;
      presc_src <= 1'b0;
      mode_select_field <= 4'h0;
    end else if (ctrl_wr) begin
      timer_enable_bit <= bus_req.wdata[BIT_EN];
      overflow_irq_enable <= bus_req.wdata[BIT_OVERFLOW_IRQ_ENABLE];
      compare_irq_enable <= bus_req.wdata[BIT_COMPARE_IRQ_ENABLE];
      polarity_select <= bus_req.wdata[BIT_POL];
      mode_select_field <= bus_req.wdata[MODE_HI:MODE_LO];
      reload_mode <= bus_req.wdata[BIT_RELOAD];
      presc_src <= bus_req.wdata[BIT_PSRC];
    end
  end

  // ----------------------------------------------------------------
  // load and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      load_value_reg <= ZERO24;
      compare_value_reg <= ZERO24;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_LOAD) begin
        load_value_reg <= bus_req.wdata;
      end
      if (bus_req.addr == ADDR_CMP) begin
        compare_value_reg <= bus_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser and edge find
  // ----------------------------------------------------------------
  // first stage feeds only the second; edges compare settled samples
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_reg <= '0;
      samp_prev_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[0], timer_io_pin_i};
      samp_prev_reg <= sync_reg[SYNC_STAGES-1];
    end
  end

  wire samp = sync_reg[SYNC_STAGES-1];
  wire rise = samp && !samp_prev_reg;
  wire fall = !samp && samp_prev_reg;
  wire sel_edge = polarity_select ? fall : rise;
  wire opp_edge = polarity_select ? rise : fall;

  // ----------------------------------------------------------------
  // timer clock and counter
  // ----------------------------------------------------------------
  wire is_event = mode_select_field == MODE_EVENT;
  wire is_width = mode_select_field == MODE_WIDTH;
  wire is_period = mode_select_field == MODE_PERIOD;
  wire is_capture = mode_select_field == MODE_CAPTURE;
  wire is_pwm = mode_select_field == MODE_PWM;
  wire is_toggle = mode_select_field == MODE_TOGGLE;
  wire is_meas = is_width || is_period;
  // event mode counts pin edges or prescaler ticks; others count every cycle
  wire tclk = is_event ? (presc_src ? presc_tick : sel_edge) : 1'b1;
  wire running = timer_enable_bit && state_reg == ST_RUN;
  wire at_max = count_reg == ALL_ONES;
  // a match needs a settled count: not on a loading clock, not with a reload due
  wire match = running && tclk && !first_reg && !reload_pend_reg
               && count_reg == compare_value_reg;
  wire ovf = running && tclk && !first_reg && !reload_pend_reg && at_max;
  wire cnt_mode = is_toggle || is_event || is_pwm;
  // pwm reloads on overflow alone: reloading at its compare point would cut
  // the period short and break the duty figure
  wire reload_now = reload_mode && cnt_mode && ((match && !is_pwm) || ovf);
  // measurement edges; counts are one synchroniser delay late
  wire width_stop = is_width && running && !first_reg && opp_edge;
  wire period_hit = is_period && running && !first_reg && sel_edge;
  wire cap_hit = is_capture && running && sel_edge;
  wire meas_hit = width_stop || period_hit || cap_hit;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // width and period wait for a start edge; all other modes run at once
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else if (en_rise) begin
      state_reg <= start_armed ? ST_ARMED : ST_RUN;
    end else if (!timer_enable_bit) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= ST_IDLE;
        ST_ARMED: if (sel_edge) state_reg <= ST_RUN;
        ST_RUN: begin
          if (cap_hit) begin
            state_reg <= ST_HALT;
          end else if (width_stop) begin
            state_reg <= reload_mode ? ST_ARMED : ST_RUN;
          end
        end
        ST_HALT: state_reg <= ST_HALT;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // load sequencing
  // ----------------------------------------------------------------
  // first pending: next timer clock loads the load value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      first_reg <= 1'b0;
      reload_pend_reg <= 1'b0;
    end else if (en_rise) begin
      first_reg <= 1'b1;
      reload_pend_reg <= 1'b0;
    end else begin
      if (state_reg == ST_ARMED && sel_edge) begin
        first_reg <= 1'b1;
      end else if (running && tclk && first_reg) begin
        first_reg <= 1'b0;
      end
      // counting modes reload on the match or overflow edge itself, so only the period
      // measurement keeps a reload pending for its next clock
      if (period_hit && reload_mode) begin
        reload_pend_reg <= 1'b1;
      end else if (running && tclk) begin
        reload_pend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a width-stop or capture edge freezes the count on the edge that captures it; a period edge lets it advance
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_reg <= ZERO24;
    end else if (en_rise) begin
      count_reg <= ZERO24;
    end else if (running && tclk && !cap_hit && !width_stop) begin
      if (first_reg || reload_pend_reg || reload_now) begin
        count_reg <= load_value_reg;
      end else begin
        count_reg <= count_reg + 24'h000001; // wraps past all-ones
      end
    end
  end

  // ----------------------------------------------------------------
  // readout, flags and pin
  // ----------------------------------------------------------------
  // measuring modes change the readout only on their capture edge; the
  // toggle and event modes let it follow the live count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_readout_reg <= ZERO24;
    end else if (meas_hit || (match && is_pwm)) begin
      count_readout_reg <= count_reg;
    end else if (ovf && is_pwm && !reload_mode) begin
      count_readout_reg <= load_value_reg;
    end else if (!is_meas && !is_capture && !is_pwm) begin
      count_readout_reg <= count_reg;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  wire cmp_clr = ctrl_wr && bus_req.wdata[BIT_TCF];
  wire ovf_clr = ctrl_wr && bus_req.wdata[BIT_TOF];
  wire cmp_set = (match && (is_toggle || is_event || is_pwm)) || meas_hit;

  // set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      compare_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (cmp_set) begin
        compare_flag <= 1'b1;
      end else if (cmp_clr || compare_ack) begin
        compare_flag <= 1'b0;
      end
      if (ovf) begin
        overflow_flag <= 1'b1;
      end else if (ovf_clr || overflow_ack) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      compare_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      // requests track the flag's next value, so a set beats a same-cycle clear
      compare_irq <= compare_irq_enable
                     && (cmp_set || (compare_flag && !cmp_clr && !compare_ack));
      overflow_irq <= overflow_irq_enable
                      && (ovf || (overflow_flag && !ovf_clr && !overflow_ack));
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  wire out_mode = is_toggle || is_pwm;
  // the enable follows the control word as written, so the pin turns round
  // on the edge that takes the write rather than one cycle after it
  wire oe_next = en_next && (mode_next == MODE_TOGGLE || mode_next == MODE_PWM);
  // pin_reg is the level the mode wants; the port flop below launches it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_reg <= 1'b0;
    end else if (en_rise) begin
      pin_reg <= bus_req.wdata[BIT_POL];
    end else if ((match && out_mode) || (ovf && is_pwm)) begin
      pin_reg <= !pin_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      timer_io_pin <= '0;
    end else begin
      timer_io_pin.pin_o <= (en_rise ? bus_req.wdata[BIT_POL] : pin_reg);
      timer_io_pin.pin_oe <= oe_next;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata <= ZERO24;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CTRL: begin
          rdata <= CTRL_RESET;
          rdata[BIT_EN] <= timer_enable_bit;
          rdata[BIT_OVERFLOW_IRQ_ENABLE] <= overflow_irq_enable;
          rdata[BIT_COMPARE_IRQ_ENABLE] <= compare_irq_enable;
          rdata[BIT_POL] <= polarity_select;
          rdata[MODE_HI:MODE_LO] <= mode_select_field;
          rdata[BIT_RELOAD] <= reload_mode;
          rdata[BIT_PSRC] <= presc_src;
          rdata[BIT_PIN_IN] <= samp;
          rdata[BIT_TOF] <= overflow_flag;
          rdata[BIT_TCF] <= compare_flag;
        end
        ADDR_CMP: rdata <= compare_value_reg;
        ADDR_COUNT: rdata <= count_readout_reg;
        default: rdata <= ZERO24; // load register is write-only
      endcase
    end else begin
      rdata <= ZERO24;
    end
  end
endmodule

// ===== core/ttm_pkg.sv
// Purpose: shared constants and types for the timer channel
// Assumes: one 24-bit channel, plain register port
// Notes: word offsets below are byte addresses on the register port
package ttm_pkg;
  localparam int CW = 24;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LOAD = 4'h4;
  localparam logic [3:0] ADDR_CMP = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hC;
  localparam logic [3:0] ADDR_PRESC = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
  // control and status layout
  localparam int BIT_EN = 0;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 1;
  localparam int BIT_COMPARE_IRQ_ENABLE = 2;
  localparam int BIT_POL = 3;
  localparam int MODE_LO = 4;
  localparam int MODE_HI = 7;
  localparam int BIT_RELOAD = 9;
  localparam int BIT_PSRC = 15;
  localparam int BIT_PIN_IN = 19;
  localparam int BIT_TOF = 20;
  localparam int BIT_TCF = 21;
  localparam logic [CW-1:0] CTRL_RESET = 24'h000000;
  localparam logic [CW-1:0] ZERO24 = 24'h000000;
  localparam logic [CW-1:0] ALL_ONES = 24'hFFFFFF;
  localparam int SYNC_STAGES = 2;
  // operating modes
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_EVENT = 4'h3;
  localparam logic [3:0] MODE_WIDTH = 4'h4;
  localparam logic [3:0] MODE_PERIOD = 4'h5;
  localparam logic [3:0] MODE_CAPTURE = 4'h6;
  localparam logic [3:0] MODE_PWM = 4'h7;

  typedef struct packed {
    logic [3:0] addr;
    logic [CW-1:0] wdata;
    logic wr;
    logic rd;
  } ttm_bus_req_t;

  typedef struct packed {
    logic pin_o;
    logic pin_oe;
  } ttm_pin_out_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HALT = 4'b1000
  } ttm_state_t;
endpackage

// ===== tb/ttm_monitor.sv
// Purpose: port-level checks for the timer channel
// Assumes: ctrl shadow follows software writes to the control word
// Notes: flags are internal, so irq lines stand in for them
`timescale 1ns/1ps
module ttm_monitor
  import ttm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // watched ports
  input wire ttm_pkg::ttm_bus_req_t bus_req,
  input wire logic [ttm_pkg::CW-1:0] rdata,
  input wire logic compare_ack,
  input wire logic overflow_ack,
  input wire logic presc_tick,
  input wire logic timer_io_pin_i,
  input wire ttm_pkg::ttm_pin_out_t timer_io_pin,
  input wire logic compare_irq,
  input wire logic overflow_irq
);
  logic [CW-1:0] ctrl_q;
  logic [3:0] md;
  logic [3:0] wm;
  logic oe_want;
  logic en_wr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge core_clk) begin
    if (reset) ctrl_q <= CTRL_RESET;
    else if (bus_req.wr && bus_req.addr == ADDR_CTRL) ctrl_q <= bus_req.wdata;
  end
  assign md = ctrl_q[MODE_HI:MODE_LO];
  assign wm = bus_req.wdata[MODE_HI:MODE_LO];
  assign oe_want = ctrl_q[BIT_EN] && (md == MODE_TOGGLE || md == MODE_PWM);
  assign en_wr = bus_req.wr && bus_req.addr == ADDR_CTRL && bus_req.wdata[BIT_EN] && !ctrl_q[BIT_EN];
  a_pin_drive_mode: assert property (timer_io_pin.pin_oe == oe_want)
    else $error("pin drive does not match mode");
  a_toggle_start_level: assert property (en_wr && wm == MODE_TOGGLE |=>
    timer_io_pin.pin_o == $past(bus_req.wdata[BIT_POL])) else $error("toggle start level");
  a_pwm_start_level: assert property (en_wr && wm == MODE_PWM |=>
    timer_io_pin.pin_o == $past(bus_req.wdata[BIT_POL])) else $error("pwm start level");
  a_toggle_raises_irq: assert property ($changed(timer_io_pin.pin_o) && $past(oe_want)
    && oe_want && md == MODE_TOGGLE && ctrl_q[BIT_COMPARE_IRQ_ENABLE] |=> compare_irq) else $error("no irq");
  a_cmp_irq_gated: assert property ($rose(compare_irq) |-> ctrl_q[BIT_COMPARE_IRQ_ENABLE]
    || $past(ctrl_q[BIT_COMPARE_IRQ_ENABLE])) else $error("compare irq while disabled");
  a_ovf_irq_gated: assert property ($rose(overflow_irq) |-> ctrl_q[BIT_OVERFLOW_IRQ_ENABLE]
    || $past(ctrl_q[BIT_OVERFLOW_IRQ_ENABLE])) else $error("overflow irq while disabled");
  a_cmp_ack_clears: assert property (compare_ack && md == MODE_CAPTURE |-> ##[1:2] !compare_irq)
    else $error("compare ack ignored");
  a_ovf_ack_clears: assert property (overflow_ack && !ctrl_q[BIT_EN] |-> ##[1:2] !overflow_irq)
    else $error("overflow ack ignored");
  c_toggle: cover property (oe_want && $changed(timer_io_pin.pin_o));
  c_cmp_irq: cover property ($rose(compare_irq));
  c_ovf_irq: cover property ($rose(overflow_irq));
endmodule

// ===== tb/ttm_pin_src.sv
// Purpose: outside signal source on the timer pin
// Assumes: device drive wins while its enable is high
// Notes: levels change only just after a clock edge
`timescale 1ns/1ps
module ttm_pin_src
  import ttm_pkg::*;
(
  input wire logic core_clk,
  input wire ttm_pkg::ttm_pin_out_t pin_drv,
  output logic pin_level
);
  logic src_lvl = 1'b0;
  assign pin_level = pin_drv.pin_oe ? pin_drv.pin_o : src_lvl;
  // hold of three or more cycles keeps the source below a quarter of core_clk
  task automatic drive(input logic lvl, input int hold);
    @(posedge core_clk);
    src_lvl <= lvl;
    repeat (hold) @(posedge core_clk);
  endtask
endmodule

// ===== tb/ttm_timer_tb.sv
// Purpose: self-checking bench for the timer channel
// Assumes: ctrl layout and offsets of the package
// Notes: measured counts are checked as ranges, sync adds slack
`timescale 1ns/1ps
module ttm_timer_tb;
  import ttm_pkg::*;
  logic core_clk, reset, compare_ack, overflow_ack, presc_tick, pin_lvl;
  ttm_bus_req_t bus_req;
  logic [CW-1:0] rdata, rv;
  ttm_pin_out_t pin_out;
  logic compare_irq, overflow_irq;
  int miscompares = 0, total_checks = 0, cyc = 0, n1, n2;
  ttm_timer DUT (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .compare_ack(compare_ack), .overflow_ack(overflow_ack), .presc_tick(presc_tick),
    .timer_io_pin_i(pin_lvl), .timer_io_pin(pin_out), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq));
  ttm_pin_src src (.core_clk(core_clk), .pin_drv(pin_out), .pin_level(pin_lvl));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [CW-1:0] seen, input logic [CW-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [CW-1:0] d);
    bus_req <= {a, d, 2'b10};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [CW-1:0] v);
    bus_req <= {a, ZERO24, 2'b01};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(posedge core_clk);
    v = rdata;
  endtask
  task automatic wait_pin(output int n);
    logic p;
    p = pin_out.pin_o;
    n = 0;
    while (pin_out.pin_o === p && n < 200) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic pulse_ack(input bit sel_ovf);
    if (sel_ovf) overflow_ack <= 1'b1;
    else compare_ack <= 1'b1;
    @(posedge core_clk);
    overflow_ack <= 1'b0;
    compare_ack <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic meas(input logic [3:0] m, input logic p, input int g, input int lo, input int hi);
    logic [CW-1:0] v;
    src.drive(p, 3);
    wr(ADDR_CTRL, {16'h0000, m, p, 3'b101});
    if (m == MODE_CAPTURE) repeat (g) @(posedge core_clk);
    else if (m == MODE_WIDTH) src.drive(!p, g);
    else begin
      src.drive(!p, g / 2);
      src.drive(p, g / 2);
    end
    src.drive(m == MODE_WIDTH ? p : !p, 3);
    repeat (4) @(posedge core_clk);
    rd(ADDR_COUNT, v);
    check("measured count", v >= lo && v <= hi, 1'b1);
    check("measure irq", compare_irq, 1'b1);
    repeat (10) @(posedge core_clk);
    rd(ADDR_COUNT, rv);
    check("readout held", rv, v);
    pulse_ack(1'b0);
    check("ack clears irq", compare_irq, 1'b0);
    wr(ADDR_CTRL, ZERO24);
    $display("measure mode %0d done", m);
  endtask
  initial begin
    bus_req = '0;
    reset = 1'b1;
    compare_ack = 1'b0;
    overflow_ack = 1'b0;
    presc_tick = 1'b0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_CTRL, rv);
    check("ctrl reset", rv, CTRL_RESET);
    rd(4'h2, rv);
    check("unmapped read", rv, ZERO24);
    // toggle: reload spacing is compare - load + 1
    wr(ADDR_LOAD, 24'h000004);
    wr(ADDR_CMP, 24'h000008);
    rd(ADDR_CMP, rv);
    check("compare readback", rv, 24'h000008);
    wr(ADDR_CTRL, 24'h00022D);
    check("toggle start", pin_out, 2'b11);
    wait_pin(n1);
    wait_pin(n2);
    check("toggle spacing", n2, 5);
    @(posedge core_clk);
    check("toggle irq", compare_irq, 1'b1);
    wr(ADDR_CTRL, ZERO24);
    rd(ADDR_CTRL, rv);
    check("flag set", rv[BIT_TCF], 1'b1);
    wr(ADDR_CTRL, 24'h200000);
    rd(ADDR_CTRL, rv);
    check("flag w1c", rv[BIT_TCF], 1'b0);
    $display("toggle done");
    // event counting on falling pin edges, then on prescaler ticks
    wr(ADDR_LOAD, ZERO24);
    wr(ADDR_CMP, 24'h000003);
    for (int s = 0; s < 2; s++) begin
      src.drive(1'b1, 3);
      wr(ADDR_CTRL, s ? 24'h00803D : 24'h00003D);
      // the first event loads the counter, the fifth meets the compare value
      for (int k = 1; k <= 5; k++) begin
        if (s == 1) begin
          presc_tick <= 1'b1;
          @(posedge core_clk);
          presc_tick <= 1'b0;
          repeat (4) @(posedge core_clk);
        end else begin
          src.drive(1'b0, 3);
          src.drive(1'b1, 3);
        end
        if (k == 2) check("event early", compare_irq, 1'b0);
      end
      repeat (6) @(posedge core_clk);
      check("event match", compare_irq, 1'b1);
      wr(ADDR_CTRL, 24'h200000);
    end
    $display("event done");
    meas(MODE_WIDTH, 1'b0, 19, 18, 22);
    meas(MODE_PERIOD, 1'b1, 20, 20, 24);
    meas(MODE_CAPTURE, 1'b1, 30, 28, 38);
    // pwm near the top of the count keeps the period short
    wr(ADDR_LOAD, 24'hFFFFF0);
    wr(ADDR_CMP, 24'hFFFFF8);
    wr(ADDR_CTRL, 24'h000277);
    check("pwm start", pin_out, 2'b01);
    wait_pin(n1);
    check("pwm first toggle", pin_out.pin_o, 1'b1);
    wait_pin(n1);
    wait_pin(n2);
    check("pwm period", n1 + n2, 16);
    check("pwm duty", n1 >= 7 && n1 <= 8, 1'b1);
    check("pwm overflow irq", overflow_irq, 1'b1);
    // stop the timer but keep the overflow request enabled, so the ack has work
    wr(ADDR_CTRL, 24'h000276);
    pulse_ack(1'b1);
    check("overflow ack", overflow_irq, 1'b0);
    $display("pwm done");
    wrap_up();
  end
endmodule
bind ttm_timer ttm_monitor mon (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
  .rdata(rdata), .compare_ack(compare_ack), .overflow_ack(overflow_ack),
  .presc_tick(presc_tick), .timer_io_pin_i(timer_io_pin_i), .timer_io_pin(timer_io_pin),
  .compare_irq(compare_irq), .overflow_irq(overflow_irq));
